//--- hw/pib_bank.sv
// Peripheral interrupt enable/flag bank with APB register access.
// Assumes synchronous one-cycle event pulses and a core that acks entry.
`include "pib_map.svh"
`default_nettype none

// Contract
// - Enable one holds gate bit7, converter bit6, match bit1, overflow bit0.
// - Enable two implements only bit 2, oscillator-core enable.
// - Enable three holds cell B enable bit1, cell A enable bit0.
// - Flag one mirrors enable one layout; one means pending.
// - Flag two implements only bit 2, oscillator-core pending.
// - Flag three holds cell B pending bit1, cell A pending bit0.
// - No peripheral request reaches the core without peripheral enable.
// - Flags set on events regardless of any enable bit.
// - Unimplemented enable and flag bits read as zero.
// - Implemented bits are read/write and reset to zero.
// - Global enable clear blocks all interrupt redirection.
// - A taken interrupt loads vector address 0004h.
module pib_bank
    import pib_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        ce,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    // Peripheral event pulses
    input  wire pib_events_s events,
    // Core side
    input  wire logic        irq_ack,
    output logic             periph_req,
    output pib_core_req_s    core_req,
    // Summary interrupt
    output logic             irq
);
    logic [7:0]    gctrl_reg,  gctrl_next;
    logic [7:0]    en1_reg,    en1_next;
    logic [7:0]    en2_reg,    en2_next;
    logic [7:0]    en3_reg,    en3_next;
    logic [7:0]    flg1_reg,   flg1_next;
    logic [7:0]    flg2_reg,   flg2_next;
    logic [7:0]    flg3_reg,   flg3_next;
    logic [2:0]    istat_reg,  istat_next;
    logic [2:0]    imask_reg,  imask_next;
    logic [31:0]   rdata_reg,  rdata_next;
    logic          rdhold_reg, rdhold_next;
    pib_core_req_s creq_reg,   creq_next;
    logic [7:0]    ev1;
    logic [7:0]    ev2;
    logic [7:0]    ev3;
    logic          wr;
    logic          rd;
    logic          rd_take;
    logic          any_pend;
    logic          req_now;
    logic [2:0]    evt_stat;

    assign wr      = psel && penable && pwrite;
    assign rd      = psel && penable && !pwrite;
    // Reads insert one wait state: the word is captured into a flop on
    // the first access edge and handed over with pready on the second
    assign rd_take = rd && !rdhold_reg;
    assign pready  = ce && (pwrite || rdhold_reg);
    assign pslverr = 1'b0;
    assign prdata  = rdata_reg;

    // Event vectors placed at their register positions
    always_comb begin
        ev1 = 8'h00;
        ev2 = 8'h00;
        ev3 = 8'h00;
        ev1[`PIB_BIT_T1_GATE]  = events.timer_one_gate;
        ev1[`PIB_BIT_CONV]     = events.converter_done;
        ev1[`PIB_BIT_T2_MATCH] = events.timer_two_match;
        ev1[`PIB_BIT_T1_OVF]   = events.timer_one_overflow;
        ev2[`PIB_BIT_OSC]      = events.osc_core;
        ev3[`PIB_BIT_CELL_B]   = events.logic_cell_b;
        ev3[`PIB_BIT_CELL_A]   = events.logic_cell_a;
    end

    assign any_pend = |(flg1_reg & en1_reg) || |(flg2_reg & en2_reg)
                   || |(flg3_reg & en3_reg);
    assign req_now  = any_pend && gctrl_reg[`PIB_BIT_PERIPHERAL_IRQ_MASTER_EN]
                   && gctrl_reg[`PIB_BIT_GIE];
    assign periph_req = req_now;
    assign core_req   = creq_reg;
    assign evt_stat   = {|ev3, |ev2, |ev1};
    assign irq        = |(istat_reg & imask_reg);

    always_comb begin
        gctrl_next = gctrl_reg;
        en1_next   = en1_reg;
        en2_next   = en2_reg;
        en3_next   = en3_reg;
        flg1_next  = flg1_reg;
        flg2_next  = flg2_reg;
        flg3_next  = flg3_reg;
        imask_next = imask_reg;
        istat_next = istat_reg;
        rdata_next = rdata_reg;
        creq_next  = creq_reg;
        rdhold_next = rd_take;
        if (wr) begin
            case (paddr)
                `PIB_OFF_GCTRL: gctrl_next = pwdata[7:0] & `PIB_MASK_GCTRL;
                `PIB_OFF_EN1:   en1_next   = pwdata[7:0] & `PIB_MASK_1;
                `PIB_OFF_EN2:   en2_next   = pwdata[7:0] & `PIB_MASK_2;
                `PIB_OFF_EN3:   en3_next   = pwdata[7:0] & `PIB_MASK_3;
                `PIB_OFF_FLG1:  flg1_next  = pwdata[7:0] & `PIB_MASK_1;
                `PIB_OFF_FLG2:  flg2_next  = pwdata[7:0] & `PIB_MASK_2;
                `PIB_OFF_FLG3:  flg3_next  = pwdata[7:0] & `PIB_MASK_3;
                `PIB_OFF_IMASK: imask_next = pwdata[2:0];
                default: begin
                end
            endcase
        end
        // Events are ORed after the write so a same-cycle clear loses
        flg1_next = flg1_next | ev1;
        flg2_next = flg2_next | ev2;
        flg3_next = flg3_next | ev3;
        if (rd_take) begin
            case (paddr)
                `PIB_OFF_GCTRL: rdata_next = {24'h000000, gctrl_reg};
                `PIB_OFF_EN1:   rdata_next = {24'h000000, en1_reg};
                `PIB_OFF_EN2:   rdata_next = {24'h000000, en2_reg};
                `PIB_OFF_EN3:   rdata_next = {24'h000000, en3_reg};
                `PIB_OFF_FLG1:  rdata_next = {24'h000000, flg1_reg};
                `PIB_OFF_FLG2:  rdata_next = {24'h000000, flg2_reg};
                `PIB_OFF_FLG3:  rdata_next = {24'h000000, flg3_reg};
                `PIB_OFF_ISTAT: rdata_next = {29'h0, istat_reg};
                `PIB_OFF_IMASK: rdata_next = {29'h0, imask_reg};
                default:        rdata_next = 32'h00000000;
            endcase
            if (paddr == `PIB_OFF_ISTAT) begin
                istat_next = 3'h0;
            end
        end
        // Set wins over the read-to-clear
        istat_next = istat_next | evt_stat;
        // Entry clears global enable so nested events only record flags
        if (irq_ack && req_now) begin
            gctrl_next[`PIB_BIT_GIE] = 1'b0;
        end
        creq_next.irq_take    = req_now && !irq_ack;
        creq_next.vector_addr = `PIB_VECTOR;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            gctrl_reg <= `PIB_RESET_VAL;
            en1_reg   <= `PIB_RESET_VAL;
            en2_reg   <= `PIB_RESET_VAL;
            en3_reg   <= `PIB_RESET_VAL;
            flg1_reg  <= `PIB_RESET_VAL;
            flg2_reg  <= `PIB_RESET_VAL;
            flg3_reg  <= `PIB_RESET_VAL;
            istat_reg <= 3'h0;
            imask_reg <= 3'h0;
            rdata_reg <= 32'h00000000;
            creq_reg  <= '0;
            rdhold_reg <= 1'b0;
        end else if (ce) begin
            gctrl_reg <= gctrl_next;
            en1_reg   <= en1_next;
            en2_reg   <= en2_next;
            en3_reg   <= en3_next;
            flg1_reg  <= flg1_next;
            flg2_reg  <= flg2_next;
            flg3_reg  <= flg3_next;
            istat_reg <= istat_next;
            imask_reg <= imask_next;
            rdata_reg <= rdata_next;
            creq_reg  <= creq_next;
            rdhold_reg <= rdhold_next;
        end
    end

    // Assertions
    property p_flag_sets;
        @(posedge mclk) disable iff (rst)
        (ce && events.timer_one_gate) |=> flg1_reg[`PIB_BIT_T1_GATE];
    endproperty
    a_flag_sets: assert property (p_flag_sets) else $error("gate flag not set");

    property p_set_wins;
        @(posedge mclk) disable iff (rst)
        (ce && wr && paddr == `PIB_OFF_FLG3 && events.logic_cell_a) |=> flg3_reg[0];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost on clear");

    property p_peripheral_irq_master_en_gate;
        @(posedge mclk) disable iff (rst)
        !gctrl_reg[`PIB_BIT_PERIPHERAL_IRQ_MASTER_EN] |-> !periph_req;
    endproperty
    a_peripheral_irq_master_en_gate: assert property (p_peripheral_irq_master_en_gate) else $error("req without peripheral_irq_master_en");

    property p_gie_gate;
        @(posedge mclk) disable iff (rst)
        !gctrl_reg[`PIB_BIT_GIE] |-> !periph_req;
    endproperty
    a_gie_gate: assert property (p_gie_gate) else $error("req without gie");

    property p_req_cause;
        @(posedge mclk) disable iff (rst)
        periph_req |-> (|(flg1_reg & en1_reg) || |(flg2_reg & en2_reg)
                        || |(flg3_reg & en3_reg));
    endproperty
    a_req_cause: assert property (p_req_cause) else $error("req without source");

    property p_unimpl_zero;
        @(posedge mclk) disable iff (rst)
        (en1_reg[5:2] == 4'h0) && (flg2_reg[7:3] == 5'h00) && (flg3_reg[7:2] == 6'h00);
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("unused bit set");

    property p_vector;
        @(posedge mclk) disable iff (rst)
        core_req.irq_take |-> core_req.vector_addr == 16'h0004;
    endproperty
    a_vector: assert property (p_vector) else $error("bad vector");

    property p_en_write;
        @(posedge mclk) disable iff (rst)
        (ce && wr && paddr == `PIB_OFF_EN1) |=> en1_reg == ($past(pwdata[7:0]) & 8'hc3);
    endproperty
    a_en_write: assert property (p_en_write) else $error("enable write lost");

    property p_osc_only;
        @(posedge mclk) disable iff (rst)
        (ce && wr && paddr == `PIB_OFF_EN2) |=> en2_reg == ($past(pwdata[7:0]) & 8'h04);
    endproperty
    a_osc_only: assert property (p_osc_only) else $error("enable two layout");

    property p_cell_en;
        @(posedge mclk) disable iff (rst)
        (ce && wr && paddr == `PIB_OFF_EN3) |=> en3_reg == ($past(pwdata[7:0]) & 8'h03);
    endproperty
    a_cell_en: assert property (p_cell_en) else $error("enable three layout");

    property p_rd_wait;
        @(posedge mclk) disable iff (rst)
        (ce && rd_take) |-> !pready;
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read answered without wait");

    property p_rd_data;
        @(posedge mclk) disable iff (rst)
        (ce && rd_take && paddr == `PIB_OFF_FLG1)
            |=> prdata == {24'h000000, $past(flg1_reg)};
    endproperty
    a_rd_data: assert property (p_rd_data) else $error("flag one read data");

    property p_istat_clear;
        @(posedge mclk) disable iff (rst)
        (ce && rd_take && paddr == `PIB_OFF_ISTAT && evt_stat == 3'h0)
            |=> istat_reg == 3'h0;
    endproperty
    a_istat_clear: assert property (p_istat_clear) else $error("status not cleared");

    property p_ack_gie;
        @(posedge mclk) disable iff (rst)
        (ce && irq_ack && req_now) |=> !gctrl_reg[`PIB_BIT_GIE];
    endproperty
    a_ack_gie: assert property (p_ack_gie) else $error("entry kept gie");

    property p_flag_clear;
        @(posedge mclk) disable iff (rst)
        (ce && wr && paddr == `PIB_OFF_FLG2 && !pwdata[`PIB_BIT_OSC] && !events.osc_core)
            |=> !flg2_reg[`PIB_BIT_OSC];
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag clear lost");

    // A frozen enable must hold flag one, status and global control, events included
    property p_ce_hold;
        @(posedge mclk) disable iff (rst)
        !ce |=> ($stable(flg1_reg) && $stable(istat_reg) && $stable(gctrl_reg));
    endproperty
    a_ce_hold: assert property (p_ce_hold) else $error("state moved with ce low");

    property p_unimpl_rest;
        @(posedge mclk) disable iff (rst)
        ((en1_reg & ~`PIB_MASK_1) | (en2_reg & ~`PIB_MASK_2) | (en3_reg & ~`PIB_MASK_3)
         | (flg1_reg & ~`PIB_MASK_1) | (flg2_reg & ~`PIB_MASK_2) | (flg3_reg & ~`PIB_MASK_3)
         | (gctrl_reg & ~`PIB_MASK_GCTRL)) == 8'h00;
    endproperty
    a_unimpl_rest: assert property (p_unimpl_rest) else $error("unused bit set");

    c_req: cover property (@(posedge mclk) disable iff (rst) periph_req);
    c_set_clear: cover property (@(posedge mclk) disable iff (rst)
        wr && paddr == `PIB_OFF_FLG1 && |ev1);
    c_ack: cover property (@(posedge mclk) disable iff (rst) irq_ack && req_now);
    c_irq: cover property (@(posedge mclk) disable iff (rst) irq);
endmodule : pib_bank
`default_nettype wire

//--- hw/pib_map.svh
// Register offsets, field positions, reset values and masks for the
// peripheral interrupt enable and flag bank.
// Assumes a 32-bit APB slave with one register per aligned word.
`ifndef PIB_MAP_SVH
`define PIB_MAP_SVH

`define PIB_OFF_GCTRL     12'h000
`define PIB_OFF_EN1       12'h004
`define PIB_OFF_EN2       12'h008
`define PIB_OFF_EN3       12'h00c
`define PIB_OFF_FLG1      12'h010
`define PIB_OFF_FLG2      12'h014
`define PIB_OFF_FLG3      12'h018
`define PIB_OFF_ISTAT     12'h01c
`define PIB_OFF_IMASK     12'h020

`define PIB_BIT_T1_GATE   7
`define PIB_BIT_CONV      6
`define PIB_BIT_T2_MATCH  1
`define PIB_BIT_T1_OVF    0
`define PIB_BIT_OSC       2
`define PIB_BIT_CELL_B    1
`define PIB_BIT_CELL_A    0
`define PIB_BIT_GIE       7
`define PIB_BIT_PERIPHERAL_IRQ_MASTER_EN      6

`define PIB_MASK_1        8'hc3
`define PIB_MASK_2        8'h04
`define PIB_MASK_3        8'h03
`define PIB_MASK_GCTRL    8'hc0
`define PIB_MASK_EVT      3'h7
`define PIB_RESET_VAL     8'h00
`define PIB_VECTOR        16'h0004

`endif

//--- hw/pib_pkg.sv
// Types for the peripheral interrupt enable and flag bank.
// Assumes pib_map.svh for all numeric constants.
`default_nettype none
package pib_pkg;
    typedef struct packed {
        logic timer_one_gate;
        logic converter_done;
        logic timer_two_match;
        logic timer_one_overflow;
        logic osc_core;
        logic logic_cell_b;
        logic logic_cell_a;
    } pib_events_s;

    typedef struct packed {
        logic        irq_take;
        logic [15:0] vector_addr;
    } pib_core_req_s;
endpackage : pib_pkg
`default_nettype wire

//--- verif/pib_far_model.sv
// Behavioural peripheral event sources and core entry logic.
// Assumes the bench raises fire for one cycle per wanted event.
`default_nettype none
module pib_far_model
    import pib_pkg::*;
(
    // Clock and bench control
    input  wire logic          mclk,
    input  wire logic [6:0]    fire,
    input  wire logic [1:0]    ack_wait,
    // Bank side
    input  wire pib_core_req_s core_req,
    output pib_events_s        events,
    output logic               irq_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] wait_cnt;
    initial begin
        events = '0;
        irq_ack = 1'b0;
        wait_cnt = 2'h0;
    end
    // Sources pulse for one cycle, blind to every enable
    always @(posedge mclk) begin
        events <= fire;
    end
    // Entry is acknowledged once, after ack_wait idle cycles
    always @(posedge mclk) begin
        if (core_req.irq_take && !irq_ack && wait_cnt == ack_wait) begin
            irq_ack <= 1'b1;
            wait_cnt <= 2'h0;
        end else if (core_req.irq_take && !irq_ack) begin
            wait_cnt <= wait_cnt + 2'h1;
        end else begin
            irq_ack <= 1'b0;
        end
    end
endmodule : pib_far_model
`default_nettype wire

//--- verif/tb.sv
// Self-checking bench for the interrupt enable and flag bank.
// Assumes writes finish in one access cycle and reads after one wait state.
`include "pib_map.svh"
`default_nettype none
module tb
    import pib_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic          mclk, rst, ce, psel, penable, pwrite, pready, pslverr;
    logic          irq_ack, periph_req, irq;
    logic [11:0]   paddr;
    logic [31:0]   pwdata, prdata, q;
    logic          qerr;
    logic [6:0]    fire;
    logic [1:0]    ack_wait;
    pib_events_s   events;
    pib_core_req_s core_req;
    int            n_fail, compares, i;
    logic [11:0]   offs [7] = '{`PIB_OFF_GCTRL, `PIB_OFF_EN1, `PIB_OFF_EN2, `PIB_OFF_EN3,
                                `PIB_OFF_FLG1, `PIB_OFF_FLG2, `PIB_OFF_FLG3};
    logic [7:0]    msk [7] = '{8'hc0, 8'hc3, 8'h04, 8'h03, 8'hc3, 8'h04, 8'h03};
    logic [11:0]   ev_reg [7] = '{`PIB_OFF_FLG3, `PIB_OFF_FLG3, `PIB_OFF_FLG2,
                                  `PIB_OFF_FLG1, `PIB_OFF_FLG1, `PIB_OFF_FLG1, `PIB_OFF_FLG1};
    logic [7:0]    ev_bit [7] = '{8'h01, 8'h02, 8'h04, 8'h01, 8'h02, 8'h40, 8'h80};

    pib_bank DUT (.mclk(mclk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .events(events), .irq_ack(irq_ack),
        .periph_req(periph_req), .core_req(core_req), .irq(irq));
    pib_far_model FAR (.mclk(mclk), .fire(fire), .ack_wait(ack_wait),
        .core_req(core_req), .events(events), .irq_ack(irq_ack));

    task automatic results();
        if (n_fail == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Events in f reach the bank at the access edge of this transfer
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [6:0] f);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        fire <= f;
        @(posedge mclk);
        penable <= 1'b1;
        fire <= 7'h00;
        do @(posedge mclk); while (pready !== 1'b1);
        q = prdata;
        qerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 7'h00);
    endtask : wr
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, 7'h00);
        chk($sformatf("reg_%h", a), e, q);
        chk("pslverr", 32'h0, {31'h0, qerr});
    endtask : rdc
    // The signal is picked after the wait so the settled value is compared
    task automatic sig(input string nm, input logic e);
        logic g;
        @(negedge mclk);
        g = (nm == "irq") ? irq : (nm == "irq_take") ? core_req.irq_take : periph_req;
        chk(nm, {31'h0, e}, {31'h0, g});
    endtask : sig

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    initial begin
        #200000;
        n_fail++;
        results();
    end
    initial begin
        {rst, ce} = 2'b11;
        {psel, penable, pwrite, paddr, pwdata, fire, ack_wait} = '0;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        for (i = 0; i < 7; i++) rdc(offs[i], 32'h0);
        rdc(12'h024, 32'h0);
        for (i = 1; i < 7; i++) begin
            wr(offs[i], 32'hffffffff);
            rdc(offs[i], {24'h0, msk[i]});
            wr(offs[i], 32'h0);
        end
        // Clearing write and event collide: the event must win
        for (i = 0; i < 7; i++) begin
            apb(1'b1, ev_reg[i], 32'h0, 7'(1 << i));
            rdc(ev_reg[i], {24'h0, ev_bit[i]});
        end
        sig("periph_req", 1'b0);
        wr(`PIB_OFF_FLG1, 32'h0);
        wr(`PIB_OFF_EN1, 32'h01);
        wr(`PIB_OFF_GCTRL, 32'h80);
        apb(1'b1, `PIB_OFF_FLG2, 32'h0, 7'h08);
        sig("periph_req", 1'b0);
        wr(`PIB_OFF_GCTRL, 32'h40);
        sig("periph_req", 1'b0);
        for (i = 0; i < 3; i += 2) begin
            ack_wait <= 2'(i);
            wr(`PIB_OFF_GCTRL, 32'hc0);
            sig("periph_req", 1'b1);
            sig("irq_take", 1'b1);
            chk("vector", 32'h0004, {16'h0, core_req.vector_addr});
            repeat (8) @(posedge mclk);
            rdc(`PIB_OFF_GCTRL, 32'h40);
            sig("periph_req", 1'b0);
            sig("irq_take", 1'b0);
        end
        wr(`PIB_OFF_EN1, 32'h02);
        wr(`PIB_OFF_GCTRL, 32'hc0);
        sig("periph_req", 1'b0);
        rdc(`PIB_OFF_ISTAT, 32'h7);
        rdc(`PIB_OFF_ISTAT, 32'h0);
        apb(1'b1, `PIB_OFF_IMASK, 32'h2, 7'h04);
        sig("irq", 1'b1);
        rdc(`PIB_OFF_ISTAT, 32'h2);
        sig("irq", 1'b0);
        apb(1'b1, `PIB_OFF_GCTRL, 32'h0, 7'h01);
        sig("irq", 1'b0);
        rdc(`PIB_OFF_ISTAT, 32'h4);
        // An event that lands while ce is low must not be taken
        @(posedge mclk);
        ce <= 1'b0;
        fire <= 7'h40;
        @(posedge mclk);
        fire <= 7'h00;
        @(posedge mclk);
        ce <= 1'b1;
        rdc(`PIB_OFF_FLG1, 32'h01);
        // Second reset in mid-run clears every register again
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        for (i = 0; i < 7; i++) rdc(offs[i], 32'h0);
        sig("irq", 1'b0);
        results();
    end
endmodule : tb
`default_nettype wire
